/* File: src/sxe_pkg.sv */
// package for the swap/skip/table/xor execution block
package sxe_pkg;
  localparam int DATA_W = 8;
  localparam int ROM_W = 15;
  localparam int ROM_ADDR_W = 12;
  localparam int PAGE_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int HIGH_W = ROM_W - DATA_W;
  localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
  localparam logic [HIGH_W-1:0] TABLE_HIGH_LATCH_RST = 7'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [PAGE_W-1:0] ZERO_BYTE = 8'h00;
  localparam int SKIP_CYCLES = 2;
  localparam int PLAIN_CYCLES = 1;
  // operation codes presented by the decoder
  typedef enum logic [3:0] {
    SXE_OP_NOP = 4'h0,
    SXE_OP_SWAP = 4'h1,
    SXE_OP_SWAP_TO_REG = 4'h2,
    SXE_OP_SKIP_NULL = 4'h3,
    SXE_OP_COPY_SKIP_NULL = 4'h4,
    SXE_OP_SKIP_BIT_CLR = 4'h5,
    SXE_OP_TBL_CUR = 4'h6,
    SXE_OP_TBL_LAST = 4'h7,
    SXE_OP_XOR_MEM_TO_REG = 4'h8,
    SXE_OP_XOR_TO_MEM = 4'h9,
    SXE_OP_XOR_IMM = 4'ha
  } sxe_op_t;
  // execution phases
  typedef enum logic [2:0] {
    SXE_ST_EXEC = 3'b001,
    SXE_ST_TBL = 3'b010,
    SXE_ST_DUMMY = 3'b100
  } sxe_state_t;
endpackage

/* File: src/sxe_alu.sv */
// combinational data path: swap, zero test, bit test, xor
`timescale 1ns/1ps
module sxe_alu
  import sxe_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // operands
  input wire logic [WIDTH-1:0] mem_in,
  input wire logic [WIDTH-1:0] other_in,
  input wire logic [BIT_SEL_W-1:0] bit_sel_in,
  // results
  output logic [WIDTH-1:0] swapped_out,
  output logic [WIDTH-1:0] xor_out,
  output logic mem_zero_out,
  output logic xor_zero_out,
  output logic bit_clear_out
);
  localparam int HALF = WIDTH / 2;
  always_comb begin
    swapped_out = {mem_in[HALF-1:0], mem_in[WIDTH-1:HALF]};
    xor_out = mem_in ^ other_in;
    mem_zero_out = (mem_in == '0);
    xor_zero_out = (xor_out == '0);
    bit_clear_out = ~mem_in[bit_sel_in];
  end
endmodule // sxe_alu

/* File: src/sxe_exec.sv */
// execution unit for swap, skip, table read and xor instructions
//
// Contract
// - swap nibbles of addressed byte in place, flags unchanged
// - swap nibbles of addressed byte into working register, memory and flags unchanged
// - skip if byte zero: discard prefetch, dummy cycle, two cycles; else one
// - copy byte to working register, skip two cycles if zero; no flags
// - skip when selected bit is clear, two cycles; else one; no flags
// - current page table read: low byte to memory, high part to latch
// - last page table read: same transfer from last program page
// - working register xor memory into working register, zero flag only
// - memory xor working register back to memory, zero flag only
// - working register xor immediate into working register, zero flag only
`timescale 1ns/1ps
module sxe_exec
  import sxe_pkg::*;
#(
  parameter int ROM_AW = ROM_ADDR_W
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // decoded instruction
  input wire logic op_valid_in,
  input wire logic [3:0] op_code_in,
  input wire logic [BIT_SEL_W-1:0] bit_sel_in,
  input wire logic [DATA_W-1:0] immediate_in,
  // context from the core
  input wire logic [DATA_W-1:0] mem_rdata_in,
  input wire logic [DATA_W-1:0] table_pointer_in,
  input wire logic [ROM_AW-1:0] pc_in,
  input wire logic [ROM_W-1:0] rom_rdata_in,
  // handshake to fetch
  output logic op_ready_out,
  output logic discard_fetch_out,
  // data memory write
  output logic mem_we_out,
  output logic [DATA_W-1:0] mem_wdata_out,
  // program memory read for tables
  output logic rom_re_out,
  output logic [ROM_AW-1:0] rom_addr_out,
  // architectural state
  output logic [DATA_W-1:0] working_register_out,
  output logic [HIGH_W-1:0] table_high_latch_out,
  output logic zero_flag_out,
  output logic zero_flag_we_out
);
  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  sxe_op_t op;
  logic [DATA_W-1:0] alu_mem;
  logic [DATA_W-1:0] alu_other;
  logic [DATA_W-1:0] swapped;
  logic [DATA_W-1:0] xor_res;
  logic mem_zero;
  logic xor_zero;
  logic bit_clear;
  logic skip_hit;
  assign op = sxe_op_t'(op_code_in);

  // the immediate rides the memory operand so one xor serves all three xor forms
  always_comb begin
    alu_mem = mem_rdata_in;
    alu_other = working_register_out;
    if (op == SXE_OP_XOR_IMM) begin
      alu_mem = immediate_in;
    end
  end

  sxe_alu #(.WIDTH(DATA_W)) u_alu (
    .mem_in(alu_mem),
    .other_in(alu_other),
    .bit_sel_in(bit_sel_in),
    .swapped_out(swapped),
    .xor_out(xor_res),
    .mem_zero_out(mem_zero),
    .xor_zero_out(xor_zero),
    .bit_clear_out(bit_clear)
  );

  // ---------------------------------------------------------------
  // skip decision
  // ---------------------------------------------------------------
  // kept combinational: the fetch stage must drop the prefetched word at the take edge itself
  always_comb begin
    skip_hit = 1'b0;
    case (op)
      SXE_OP_SKIP_NULL: skip_hit = mem_zero;
      SXE_OP_COPY_SKIP_NULL: skip_hit = mem_zero;
      SXE_OP_SKIP_BIT_CLR: skip_hit = bit_clear;
      default: skip_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sxe_state_t state_q, state_d;
  logic [DATA_W-1:0] wreg_q, wreg_d;
  logic [HIGH_W-1:0] table_high_latch_q, table_high_latch_d;
  logic zero_q, zero_d;
  logic mem_we_q, mem_we_d;
  logic [DATA_W-1:0] mem_wdata_q, mem_wdata_d;
  logic zwe_q, zwe_d;
  logic [ROM_AW-1:0] rom_addr_q, rom_addr_d;
  logic take;

  // table reads need one cycle for the program memory to answer
  assign take = op_valid_in && (state_q == SXE_ST_EXEC);
  assign op_ready_out = (state_q == SXE_ST_EXEC);
  assign rom_re_out = (state_q == SXE_ST_TBL);
  assign rom_addr_out = rom_addr_q;

  // ---------------------------------------------------------------
  // next state and results
  // ---------------------------------------------------------------
  // the zero flag is only ever written together with its enable, so the core merges z alone
  always_comb begin
    state_d = state_q;
    wreg_d = wreg_q;
    table_high_latch_d = table_high_latch_q;
    zero_d = zero_q;
    mem_we_d = 1'b0;
    mem_wdata_d = mem_wdata_q;
    zwe_d = 1'b0;
    rom_addr_d = rom_addr_q;
    discard_fetch_out = 1'b0;
    unique case (state_q)
      SXE_ST_EXEC: begin
        if (take) begin
          case (op)
            SXE_OP_SWAP: begin
              mem_we_d = 1'b1;
              mem_wdata_d = swapped;
            end
            SXE_OP_SWAP_TO_REG: wreg_d = swapped;
            SXE_OP_SKIP_NULL: begin
              if (skip_hit) begin
                state_d = SXE_ST_DUMMY;
                discard_fetch_out = 1'b1;
              end
            end
            SXE_OP_COPY_SKIP_NULL: begin
              wreg_d = mem_rdata_in;
              if (skip_hit) begin
                state_d = SXE_ST_DUMMY;
                discard_fetch_out = 1'b1;
              end
            end
            SXE_OP_SKIP_BIT_CLR: begin
              if (skip_hit) begin
                state_d = SXE_ST_DUMMY;
                discard_fetch_out = 1'b1;
              end
            end
            SXE_OP_TBL_CUR: begin
              // current page: upper pc bits with pointer as offset
              rom_addr_d = {pc_in[ROM_AW-1:PAGE_W], table_pointer_in};
              state_d = SXE_ST_TBL;
            end
            SXE_OP_TBL_LAST: begin
              rom_addr_d = {{(ROM_AW-PAGE_W){1'b1}}, table_pointer_in};
              state_d = SXE_ST_TBL;
            end
            SXE_OP_XOR_MEM_TO_REG, SXE_OP_XOR_IMM: begin
              wreg_d = xor_res;
              zero_d = xor_zero;
              zwe_d = 1'b1;
            end
            SXE_OP_XOR_TO_MEM: begin
              mem_we_d = 1'b1;
              mem_wdata_d = xor_res;
              zero_d = xor_zero;
              zwe_d = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      SXE_ST_TBL: begin
        // the program word must be on rom_rdata_in in the cycle rom_re_out is high
        mem_we_d = 1'b1;
        mem_wdata_d = rom_rdata_in[DATA_W-1:0];
        table_high_latch_d = rom_rdata_in[ROM_W-1:DATA_W];
        state_d = SXE_ST_EXEC;
      end
      SXE_ST_DUMMY: state_d = SXE_ST_EXEC;
      default: state_d = SXE_ST_EXEC;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_q <= SXE_ST_EXEC;
      wreg_q <= WREG_RST;
      table_high_latch_q <= TABLE_HIGH_LATCH_RST;
      zero_q <= ZERO_RST;
      mem_we_q <= 1'b0;
      mem_wdata_q <= ZERO_BYTE;
      zwe_q <= 1'b0;
      rom_addr_q <= '0;
    end else begin
      state_q <= state_d;
      wreg_q <= wreg_d;
      table_high_latch_q <= table_high_latch_d;
      zero_q <= zero_d;
      mem_we_q <= mem_we_d;
      mem_wdata_q <= mem_wdata_d;
      zwe_q <= zwe_d;
      rom_addr_q <= rom_addr_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // data outputs come straight from flops; only ready, rom_re_out and discard are combinational
  assign mem_we_out = mem_we_q;
  assign mem_wdata_out = mem_wdata_q;
  assign working_register_out = wreg_q;
  assign table_high_latch_out = table_high_latch_q;
  assign zero_flag_out = zero_q;
  assign zero_flag_we_out = zwe_q;
endmodule // sxe_exec

/* File: testbench/sxe_exec_monitor.sv */
// checker for the swap/skip/table/xor execution unit
`timescale 1ns/1ps
module sxe_exec_checker
  import sxe_pkg::*;
#(
  parameter int ROM_AW = ROM_ADDR_W
) (
  // clock, reset and inputs
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic op_valid_in,
  input wire logic [3:0] op_code_in,
  input wire logic [BIT_SEL_W-1:0] bit_sel_in,
  input wire logic [DATA_W-1:0] immediate_in,
  input wire logic [DATA_W-1:0] mem_rdata_in,
  input wire logic [DATA_W-1:0] table_pointer_in,
  // outputs
  input wire logic op_ready_out,
  input wire logic discard_fetch_out,
  input wire logic mem_we_out,
  input wire logic [DATA_W-1:0] mem_wdata_out,
  input wire logic rom_re_out,
  input wire logic [ROM_AW-1:0] rom_addr_out,
  input wire logic [DATA_W-1:0] working_register_out,
  input wire logic zero_flag_out,
  input wire logic zero_flag_we_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic take = op_valid_in && op_ready_out;
  // -----------------------------------------------
  // assertions
  // -----------------------------------------------
  a_swap_in_place: assert property (take && op_code_in == 4'h1 |=>
    mem_we_out && {mem_wdata_out[3:0], mem_wdata_out[7:4]} == $past(mem_rdata_in)) else $error("swap write wrong");
  a_skip_null: assert property (take && op_code_in == 4'h3 |->
    discard_fetch_out == (mem_rdata_in == 8'h00)) else $error("skip on zero wrong");
  a_copy_skip: assert property (take && op_code_in == 4'h4 |-> discard_fetch_out == (mem_rdata_in == 8'h00)
    ##1 working_register_out == $past(mem_rdata_in)) else $error("copy and skip wrong");
  a_bit_skip: assert property (take && op_code_in == 4'h5 |->
    discard_fetch_out == !mem_rdata_in[bit_sel_in]) else $error("bit skip wrong");
  a_dummy_cycle: assert property (discard_fetch_out |=>
    !op_ready_out ##1 op_ready_out) else $error("skip not two cycles");
  a_table_timing: assert property (take && op_code_in inside {4'h6, 4'h7} |=>
    rom_re_out && !op_ready_out ##1 mem_we_out && !rom_re_out) else $error("table read timing wrong");
  a_last_page: assert property (take && op_code_in == 4'h7 |=>
    rom_addr_out == {{(ROM_AW-PAGE_W){1'b1}}, $past(table_pointer_in)}) else $error("last page address wrong");
  a_xor_imm: assert property (take && op_code_in == 4'ha |=> zero_flag_we_out &&
    working_register_out == ($past(working_register_out) ^ $past(immediate_in))) else $error("xor imm wrong");
  a_xor_to_mem: assert property (take && op_code_in == 4'h9 |=> mem_we_out &&
    mem_wdata_out == ($past(working_register_out) ^ $past(mem_rdata_in)) && zero_flag_out == (mem_wdata_out == 8'h00))
    else $error("xor to memory wrong");
  // only the xor group may move the zero flag
  a_flag_hold: assert property (!zero_flag_we_out |-> $stable(zero_flag_out)) else $error("flag moved");
  c_skip: cover property (discard_fetch_out ##1 !op_ready_out);
  c_table: cover property (rom_re_out ##1 mem_we_out);
  c_zero: cover property (zero_flag_we_out && zero_flag_out);
endmodule // sxe_exec_checker

bind sxe_exec sxe_exec_checker #(.ROM_AW(ROM_AW)) u_chk (
  .core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in),
  .op_valid_in(op_valid_in),
  .op_code_in(op_code_in),
  .bit_sel_in(bit_sel_in),
  .immediate_in(immediate_in),
  .mem_rdata_in(mem_rdata_in),
  .table_pointer_in(table_pointer_in),
  .op_ready_out(op_ready_out),
  .discard_fetch_out(discard_fetch_out),
  .mem_we_out(mem_we_out),
  .mem_wdata_out(mem_wdata_out),
  .rom_re_out(rom_re_out),
  .rom_addr_out(rom_addr_out),
  .working_register_out(working_register_out),
  .zero_flag_out(zero_flag_out),
  .zero_flag_we_out(zero_flag_we_out)
);

/* File: testbench/sxe_exec_tb_top.sv */
// self-checking bench for the execution unit
`timescale 1ns/1ps
module sxe_exec_tb_top;
  logic core_clk_in = 0, reset_n_in = 0, op_valid_in = 0, d;
  logic [3:0] op_code_in = 4'h0;
  logic [2:0] bit_sel_in = 3'h0;
  logic [7:0] immediate_in = 8'h00, mem_rdata_in = 8'h00, table_pointer_in = 8'h00;
  logic [11:0] pc_in = 12'h000, rom_addr_out;
  logic [14:0] rom_rdata_in = 15'h0000;
  logic op_ready_out, discard_fetch_out, mem_we_out, rom_re_out, zero_flag_out, zero_flag_we_out;
  logic [7:0] mem_wdata_out, working_register_out;
  logic [6:0] table_high_latch_out;
  int miscompares = 0, num_checks = 0, cyc = 0;
  always #5 core_clk_in = ~core_clk_in;
  sxe_exec DUT (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .op_valid_in(op_valid_in),
    .op_code_in(op_code_in),
    .bit_sel_in(bit_sel_in),
    .immediate_in(immediate_in),
    .mem_rdata_in(mem_rdata_in),
    .table_pointer_in(table_pointer_in),
    .pc_in(pc_in),
    .rom_rdata_in(rom_rdata_in),
    .op_ready_out(op_ready_out),
    .discard_fetch_out(discard_fetch_out),
    .mem_we_out(mem_we_out),
    .mem_wdata_out(mem_wdata_out),
    .rom_re_out(rom_re_out),
    .rom_addr_out(rom_addr_out),
    .working_register_out(working_register_out),
    .table_high_latch_out(table_high_latch_out),
    .zero_flag_out(zero_flag_out),
    .zero_flag_we_out(zero_flag_we_out)
  );
  // -----------------------------------------------
  // helpers
  // -----------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // released byte shows its inverse so a stale read cannot pass
  task automatic issue(input logic [3:0] op, input logic [7:0] m, imm, input logic [2:0] b);
    @(negedge core_clk_in);
    op_valid_in = 1;
    op_code_in = op;
    mem_rdata_in = m;
    immediate_in = imm;
    bit_sel_in = b;
    #1 d = discard_fetch_out;
    @(negedge core_clk_in);
    op_valid_in = 0;
    mem_rdata_in = ~m;
  endtask
  task automatic t_skip(input logic [3:0] op, input logic [7:0] m, input logic [2:0] b, input logic e);
    issue(op, m, 8'h00, b);
    chk("discard", e, d);
    chk("ready_dummy", !e, op_ready_out);
    if (op == 4'h4) chk("copy", m, working_register_out);
    @(negedge core_clk_in);
    chk("ready_after", 1, op_ready_out);
  endtask
  task automatic t_table(input logic [3:0] op, input logic [7:0] tp, input logic [11:0] pc, a, input logic [14:0] w);
    table_pointer_in = tp;
    pc_in = pc;
    issue(op, 8'h00, 8'h00, 0);
    chk("rom_addr", {1'b1, a}, {rom_re_out, rom_addr_out});
    rom_rdata_in = w;
    @(negedge core_clk_in);
    chk("tbl_out", {1'b1, w}, {mem_we_out, table_high_latch_out, mem_wdata_out});
    rom_rdata_in = ~w;
  endtask
  task automatic t_swap;
    issue(4'h1, 8'h3c, 8'h00, 0);
    chk("swap_mem", 9'h1c3, {mem_we_out, mem_wdata_out});
    issue(4'h2, 8'h5a, 8'h00, 0);
    chk("swap_reg", 9'h0a5, {mem_we_out, working_register_out});
  endtask
  // starts from the 8'h80 that the copy-and-skip scenario leaves in the working register
  task automatic t_xor;
    issue(4'ha, 8'h00, 8'h80, 0);
    chk("xor_imm", 10'h300, {zero_flag_we_out, zero_flag_out, working_register_out});
    issue(4'h8, 8'h0f, 8'h00, 0);
    chk("xor_reg", 10'h20f, {zero_flag_we_out, zero_flag_out, working_register_out});
    issue(4'h9, 8'hf0, 8'h00, 0);
    chk("xor_mem", 11'h6ff, {mem_we_out, zero_flag_we_out, zero_flag_out, mem_wdata_out});
    chk("latch_hold", 7'h2a, table_high_latch_out);
    issue(4'h0, 8'h55, 8'h00, 0);
    chk("nop_hold", 16'h2a0f, {mem_we_out, table_high_latch_out, working_register_out});
  endtask
  task tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk_in);
    @(negedge core_clk_in) reset_n_in = 1;
    t_swap();
    t_skip(4'h3, 8'h00, 0, 1);
    t_skip(4'h3, 8'h01, 0, 0);
    t_skip(4'h4, 8'h00, 0, 1);
    t_skip(4'h4, 8'h80, 0, 0);
    t_skip(4'h5, 8'hfb, 2, 1);
    t_skip(4'h5, 8'h04, 2, 0);
    t_table(4'h6, 8'h12, 12'h3a5, 12'h312, 15'h5abc);
    t_table(4'h7, 8'hc4, 12'h3a5, 12'hfc4, 15'h2a5b);
    t_xor();
    tally_and_finish();
  end
endmodule // sxe_exec_tb_top
